/* File: hdl/fcsr_regs.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
`default_nettype none
module fcsr_regs (
    input wire logic core_clk, // bus clock
    input wire logic rst_n, // sync reset, active low
    input wire logic [fcsr_pkg::ADDR_W-1:0] reg_addr, // register address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [7:0] reg_rdata, // read data, cycle after strobe
    input wire logic nv_load_valid, // security byte read done
    input wire logic [7:0] nv_security_byte, // byte from flash
    input wire logic nv_double_fault, // uncorrectable error on that read
    input wire logic backdoor_unlock, // one-cycle unlock pulse
    input wire logic command_complete_flag, // high when no command runs
    output logic timebase_tick, // about 1 MHz pulse
    output logic key_access_open, // backdoor key usable
    output logic part_secured, // part secured
    output logic [2:0] command_index_field, // parameter word index
    output logic guard_loaded // guard state valid
);
    logic divider_loaded_flag;
    logic divider_lock_bit;
    logic [5:0] divide_value;
    logic [7:0] flash_guard_state;
    logic [2:0] index_field;
    logic special_mode;
    logic forced_unsecure;
    logic [7:0] next_rdata;
    logic tick_raw;
    logic div_write_in_cmd;
    fcsr_pkg::fcsr_load_t load_state;
    fcsr_pkg::fcsr_load_t next_load_state;

    // address decode
    wire hit_div = (reg_addr == fcsr_pkg::ADDR_TIMEBASE_DIVIDER);
    wire hit_guard = (reg_addr == fcsr_pkg::ADDR_GUARD_STATE);
    wire hit_index = (reg_addr == fcsr_pkg::ADDR_COMMAND_WORD_INDEX);
    wire hit_ctrl = (reg_addr == fcsr_pkg::ADDR_CONTROL);
    wire hit_stat = (reg_addr == fcsr_pkg::ADDR_STATUS);
    wire wr_div = reg_wr && hit_div;
    wire wr_index = reg_wr && hit_index;
    wire wr_ctrl = reg_wr && hit_ctrl;
    wire div_open = special_mode || !divider_lock_bit;
    // in normal mode the lock may only be raised, never dropped; special mode writes it freely
    wire next_lock = special_mode ? reg_wdata[fcsr_pkg::DIV_LOCK_BIT]
                                  : (divider_lock_bit | reg_wdata[fcsr_pkg::DIV_LOCK_BIT]);
    wire key_open = (flash_guard_state[7:6] == fcsr_pkg::KEY_ENABLED);
    wire unsecured = (flash_guard_state[1:0] == fcsr_pkg::STATE_UNSECURED);
    wire load_done = (load_state == fcsr_pkg::FCSR_LOAD_DONE);
    // timebase runs only once software configured it
    wire tick_run = divider_loaded_flag;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            divider_loaded_flag <= 1'b0;
        end else if (wr_div) begin
            divider_loaded_flag <= 1'b1;
        end
    end

    // divide value and lock; bit 7 of write data never stored
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            divide_value <= fcsr_pkg::DIV_VALUE_RESET;
            divider_lock_bit <= 1'b0;
        end else if (wr_div && div_open) begin
            divide_value <= reg_wdata[5:0];
            divider_lock_bit <= next_lock;
        end
    end

    // mode select; special mode is a test-bench style control register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            special_mode <= 1'b0;
        end else if (wr_ctrl) begin
            special_mode <= reg_wdata[fcsr_pkg::CTRL_SPECIAL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            index_field <= fcsr_pkg::INDEX_RESET;
        end else if (wr_index) begin
            index_field <= reg_wdata[2:0];
        end
    end

    // reset-sequence load: waits for the flash read after reset release
    always_comb begin
        next_load_state = load_state;
        case (load_state)
            fcsr_pkg::FCSR_LOAD_IDLE: next_load_state = fcsr_pkg::FCSR_LOAD_WAIT;
            fcsr_pkg::FCSR_LOAD_WAIT: begin
                if (nv_load_valid) begin
                    next_load_state = fcsr_pkg::FCSR_LOAD_DONE;
                end
            end
            fcsr_pkg::FCSR_LOAD_DONE: next_load_state = fcsr_pkg::FCSR_LOAD_DONE;
            default: next_load_state = fcsr_pkg::FCSR_LOAD_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            load_state <= fcsr_pkg::FCSR_LOAD_IDLE;
        end else begin
            load_state <= next_load_state;
        end
    end

    // reserved bits copied only
    // guard reads all-ones (secured, key off) until the load lands
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_guard_state <= fcsr_pkg::GUARD_RESET;
        end else if (load_state == fcsr_pkg::FCSR_LOAD_WAIT && nv_load_valid) begin
            flash_guard_state <= nv_double_fault ? fcsr_pkg::GUARD_ALL_SET : nv_security_byte;
        end else if (forced_unsecure) begin
            flash_guard_state[1:0] <= fcsr_pkg::STATE_UNSECURED;
        end
    end

    // backdoor forces unsecure
    // unlock is only honoured once the load is done and keys are enabled
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            forced_unsecure <= 1'b0;
        end else if (backdoor_unlock && load_done && key_open) begin
            forced_unsecure <= 1'b1;
        end
    end

    fcsr_tick_gen #(
        .DIV_W(fcsr_pkg::DIV_VALUE_W)
    ) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(tick_run),
        .divide_value(divide_value),
        .tick(tick_raw)
    );

    // read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (hit_div) begin
            next_rdata = {divider_loaded_flag, divider_lock_bit, divide_value};
        end else if (hit_guard) begin
            next_rdata = flash_guard_state;
        end else if (hit_index) begin
            next_rdata = {5'h00, index_field};
        end else if (hit_ctrl) begin
            next_rdata = {7'h00, special_mode};
        end else if (hit_stat) begin
            next_rdata = {3'h0, div_write_in_cmd, load_done, !unsecured, key_open, tick_run};
        end
    end

    // read data held one cycle only, zero otherwise
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // registered outputs
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timebase_tick <= 1'b0;
            key_access_open <= 1'b0;
            part_secured <= 1'b1;
            command_index_field <= fcsr_pkg::INDEX_RESET;
            guard_loaded <= 1'b0;
        end else begin
            timebase_tick <= tick_raw;
            key_access_open <= key_open && load_done;
            part_secured <= !unsecured;
            command_index_field <= index_field;
            guard_loaded <= load_done;
        end
    end

    // records a divider write made while a command runs, sticky until reset
    // the write itself is still taken: keeping that rule is software's job, this only leaves a trace
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            div_write_in_cmd <= 1'b0;
        end else if (wr_div && !command_complete_flag) begin
            div_write_in_cmd <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/fcsr_pkg.sv */
`default_nettype none
package fcsr_pkg;
    // register offsets (byte addresses on the plain port)
    localparam logic [3:0] ADDR_TIMEBASE_DIVIDER = 4'h0;
    localparam logic [3:0] ADDR_GUARD_STATE = 4'h1;
    localparam logic [3:0] ADDR_COMMAND_WORD_INDEX = 4'h2;
    localparam logic [3:0] ADDR_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int ADDR_W = 4;
    // divider field layout
    localparam int DIV_LOADED_BIT = 7;
    localparam int DIV_LOCK_BIT = 6;
    localparam int DIV_VALUE_W = 6;
    localparam logic [5:0] DIV_VALUE_RESET = 6'h00;
    // guard byte layout
    localparam logic [1:0] KEY_ENABLED = 2'h2;
    localparam logic [1:0] STATE_UNSECURED = 2'h2;
    localparam logic [7:0] GUARD_ALL_SET = 8'hFF;
    localparam logic [7:0] GUARD_RESET = 8'hFF;
    // index field
    localparam int INDEX_W = 3;
    localparam logic [2:0] INDEX_RESET = 3'h0;
    // control and status bit positions
    localparam int CTRL_SPECIAL_BIT = 0;
    localparam int STAT_TICK_RUN_BIT = 0;
    localparam int STAT_KEY_OPEN_BIT = 1;
    localparam int STAT_SECURED_BIT = 2;
    localparam int STAT_LOAD_DONE_BIT = 3;
    // timebase target
    localparam int TICK_TARGET_KHZ = 1000;
    // load state machine
    typedef enum logic [1:0] {
        FCSR_LOAD_IDLE = 2'b00,
        FCSR_LOAD_WAIT = 2'b01,
        FCSR_LOAD_DONE = 2'b10
    } fcsr_load_t;
endpackage
`default_nettype wire

/* File: hdl/fcsr_tick_gen.sv */
`default_nettype none
// divides the bus clock by (divide_value + 1) into a one-cycle tick
module fcsr_tick_gen #(
    parameter int DIV_W = 6
) (
    input wire logic core_clk, // bus clock
    input wire logic rst_n, // sync reset, active low
    input wire logic run, // counting allowed
    input wire logic [DIV_W-1:0] divide_value, // terminal count
    output logic tick // one-cycle timebase pulse
);
    logic [DIV_W-1:0] count;
    wire at_end = (count >= divide_value);

    // counter restarts while not running, so the first tick is a full period
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= at_end ? '0 : count + 1'b1;
            tick <= at_end;
        end
    end
endmodule
`default_nettype wire

/* File: tb/fcsr_regs_sva.sv */
`default_nettype none
module fcsr_regs_sva (
    input wire logic core_clk, // bus clock
    input wire logic rst_n, // sync reset
    input wire logic [fcsr_pkg::ADDR_W-1:0] reg_addr, // address
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic timebase_tick, // tick
    input wire logic key_access_open, // key usable
    input wire logic part_secured, // secured
    input wire logic [2:0] command_index_field, // index
    input wire logic guard_loaded // load done
);
    logic seen_wr;
    logic spec;
    logic [6:0] div_m;
    logic [2:0] ix_m;
    wire div_wr = reg_wr && reg_addr == fcsr_pkg::ADDR_TIMEBASE_DIVIDER;
    // shadow of divider, mode and index; lock only binds outside special mode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seen_wr <= 1'b0;
            spec <= 1'b0;
            div_m <= 7'h00;
            ix_m <= 3'h0;
        end else begin
            seen_wr <= seen_wr | div_wr;
            if (reg_wr && reg_addr == fcsr_pkg::ADDR_CONTROL) spec <= reg_wdata[0];
            if (div_wr && (spec || !div_m[6])) div_m <= reg_wdata[6:0];
            if (reg_wr && reg_addr == fcsr_pkg::ADDR_COMMAND_WORD_INDEX) ix_m <= reg_wdata[2:0];
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // readback, idle and sticky relations
    a_div_readback:
        assert property ($past(reg_rd) && $past(reg_addr) == fcsr_pkg::ADDR_TIMEBASE_DIVIDER
            |-> reg_rdata == {$past(seen_wr), $past(div_m)}) else $error("divider readback wrong");
    a_index_readback:
        assert property ($past(reg_rd) && $past(reg_addr) == fcsr_pkg::ADDR_COMMAND_WORD_INDEX
            |-> reg_rdata == {5'h00, $past(ix_m)}) else $error("index readback wrong");
    a_index_stable:
        assert property (!reg_wr [*3] |-> $stable(command_index_field)) else $error("index moved");
    a_tick_idle:
        assert property (!seen_wr |-> !timebase_tick) else $error("tick before divider write");
    a_key_after_load:
        assert property (key_access_open |-> guard_loaded) else $error("key open before load");
    a_preload_secured:
        assert property (!guard_loaded |-> part_secured) else $error("unsecured before load");
    a_unlock_sticky:
        assert property (!part_secured |=> !part_secured) else $error("security returned");
    a_load_sticky:
        assert property (guard_loaded |=> guard_loaded) else $error("load flag dropped");
    a_rdata_quiet:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data without read");
endmodule
bind fcsr_regs fcsr_regs_sva chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timebase_tick, .key_access_open, .part_secured, .command_index_field, .guard_loaded);
`default_nettype wire

/* File: tb/fcsr_regs_bench.sv */
`default_nettype none
module fcsr_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [3:0] A_DIV = fcsr_pkg::ADDR_TIMEBASE_DIVIDER;
    localparam logic [3:0] A_GRD = fcsr_pkg::ADDR_GUARD_STATE;
    localparam logic [3:0] A_IDX = fcsr_pkg::ADDR_COMMAND_WORD_INDEX;
    logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic nv_load_valid = 1'b0, nv_double_fault = 1'b0, backdoor_unlock = 1'b0, command_complete_flag = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, nv_security_byte = 8'hFF, reg_rdata;
    logic [2:0] command_index_field;
    logic timebase_tick, key_access_open, part_secured, guard_loaded;
    int err_total = 0, n_tests = 0, gap;
    fcsr_regs dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .nv_load_valid,
        .nv_security_byte, .nv_double_fault, .backdoor_unlock, .command_complete_flag, .timebase_tick,
        .key_access_open, .part_secured, .command_index_field, .guard_loaded);
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk("rdata", reg_rdata, exp);
    endtask
    // bounded wait: 0 for load done, 1 for a tick
    task automatic wait_hi(input int w);
        int i;
        i = 0;
        while ((w ? timebase_tick : guard_loaded) !== 1'b1) begin
            @(posedge core_clk);
            #1 i++;
            if (i > 50) begin
                err_total++;
                results();
            end
        end
    endtask
    // reset, then hand over the security byte as a held level
    task automatic boot(input logic [7:0] b, input logic f);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        nv_security_byte <= b;
        nv_double_fault <= f;
        nv_load_valid <= 1'b1;
        wait_hi(0);
        @(posedge core_clk);
        nv_load_valid <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    task automatic unlock();
        @(posedge core_clk);
        backdoor_unlock <= 1'b1;
        @(posedge core_clk);
        backdoor_unlock <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    initial begin
        boot(8'hBE, 1'b0);
        rd(A_GRD, 8'hBE);
        wr(A_GRD, 8'h00);
        rd(A_GRD, 8'hBE);
        rd(A_DIV, 8'h00);
        wr(A_DIV, 8'h45); // value as for a 6 MHz bus; only the tick period is checked
        rd(A_DIV, 8'hC5);
        wr(A_DIV, 8'h0A);
        rd(A_DIV, 8'hC5);
        wait_hi(1);
        gap = 0;
        do begin
            @(posedge core_clk);
            #1 gap++;
        end while (timebase_tick !== 1'b1 && gap < 99);
        chk("tick gap", 8'(gap), 8'h06);
        rd(fcsr_pkg::ADDR_STATUS, 8'h0B);
        rd(fcsr_pkg::ADDR_CONTROL, 8'h00);
        wr(A_IDX, 8'hFD);
        wr(4'hF, 8'hFF);
        rd(A_IDX, 8'h05);
        chk("index", {5'h00, command_index_field}, 8'h05);
        $display("test divider done");
        boot(8'hBE, 1'b1);
        rd(A_GRD, 8'hFF);
        unlock();
        chk("secured", {7'h00, part_secured}, 8'h01);
        wr(fcsr_pkg::ADDR_CONTROL, 8'h01);
        wr(A_DIV, 8'h7F);
        wr(A_DIV, 8'h03);
        rd(A_DIV, 8'h83);
        rd(fcsr_pkg::ADDR_CONTROL, 8'h01);
        // one deliberate write while a command runs, to see it recorded
        @(posedge core_clk);
        command_complete_flag <= 1'b0;
        wr(A_DIV, 8'h03);
        command_complete_flag <= 1'b1; // idle again for every later write
        rd(fcsr_pkg::ADDR_STATUS, 8'h1D);
        $display("test fault done");
        // reserved bits left erased in every code
        for (int i = 0; i < 4; i++) begin
            boot({i[1:0], 4'hF, i[1:0]}, 1'b0);
            chk("key open", {7'h00, key_access_open}, {7'h00, i == 2});
            chk("secured", {7'h00, part_secured}, {7'h00, i != 2});
        end
        $display("test codes done");
        boot(8'hBD, 1'b0);
        unlock();
        chk("secured", {7'h00, part_secured}, 8'h00);
        rd(A_GRD, 8'hBE);
        $display("test unlock done");
        results();
    end
endmodule
`default_nettype wire
